// ---- hdl/mdc_ctrl.sv ----
`timescale 1ns/1ps
// What this block does
// R1: Each command part goes out as two ticks on consecutive rising edges.
// R2: Six command/address lines carry code, bank and address; no other address pins.
// R3: Read, write, masked write and activate send two parts back to back.
// R4: Sixteen data lanes and eight banks per channel.
// R5: Data lanes move two bits per clock, one per edge.
// R6: One access moves sixteen beats of sixteen bits.
// R7: Bursts start at the chosen column and run a fixed length in order.
// R8: A row activate must open the bank before any column access.
// R9: Read/write bank and start column come from the command's own bits.
// R10: Array traffic waits until initialization is complete.
// R11: Row width follows density: 14, 15, 16 or 17 bits; bank always three.
// R12: Non-binary density: top row bit set forces the next bit low.
// R13: Column is ten bits; the low two are zero and never sent.
// R14: Unused row and column bits are driven to defined levels.
// R15: From self refresh only power-down, mode reads/writes and multipurpose are allowed.
// R16: Device samples command lines on the rising clock edge.
// R17: Reset pin low forces the device into reset from any state.
// R18: Mode writes with a bank open may only touch non-timing fields; not checked here, cmd_arg goes out as given.
module mdc_ctrl #(
	parameter int unsigned INIT1_CYC = mdc_pkg::INIT1_CYC,
	parameter int unsigned INIT3_CYC = mdc_pkg::INIT3_CYC
) (
	input  wire logic                            ref_clk,
	input  wire logic                            reset_n,
	input  wire mdc_pkg::mdc_den_t               density,
	input  wire logic                            init_done,
	input  wire logic                            cmd_valid,
	output wire logic                            cmd_ready,
	input  wire mdc_pkg::mdc_op_t                cmd_op,
	input  wire logic [mdc_pkg::BANK_W-1:0]      cmd_bank,
	input  wire logic [mdc_pkg::ROW_W-1:0]       cmd_row,
	input  wire logic [mdc_pkg::COL_W-1:0]       cmd_col,
	input  wire logic [mdc_pkg::CA_W-1:0]        cmd_arg,
	output logic                                 cmd_err,
	input  wire logic                            wr_valid,
	output wire logic                            wr_ready,
	input  wire logic [mdc_pkg::WORD_W-1:0]      wr_data,
	output logic                                 rd_valid,
	output logic [mdc_pkg::WORD_W-1:0]           rd_data,
	output logic [mdc_pkg::NBANK-1:0]            bank_open,
	output logic                                 self_refresh,
	output logic                                 dram_reset_n,
	output logic                                 dram_cke,
	output logic                                 dram_cs,
	output logic [mdc_pkg::CA_W-1:0]             dram_ca,
	output logic [mdc_pkg::DQ_W-1:0]             dq_out_rise,
	output logic [mdc_pkg::DQ_W-1:0]             dq_out_fall,
	output logic                                 dq_oe,
	input  wire logic [mdc_pkg::DQ_W-1:0]        dq_in_rise,
	input  wire logic [mdc_pkg::DQ_W-1:0]        dq_in_fall,
	output logic                                 dqs_out,
	output logic                                 dqs_oe
);
	typedef enum logic [2:0] {ST_RST, ST_CKE, ST_IDLE, ST_SEND, ST_WAIT, ST_WDATA, ST_RDATA}
		mdc_state_t;

	localparam logic [mdc_pkg::CNT_W-1:0] INIT1_LAST = mdc_pkg::CNT_W'(INIT1_CYC - 1);
	localparam logic [mdc_pkg::CNT_W-1:0] INIT3_LAST = mdc_pkg::CNT_W'(INIT3_CYC - 1);
	localparam logic [mdc_pkg::CNT_W-1:0] WL_LAST    = mdc_pkg::CNT_W'(mdc_pkg::WL_CYC - 1);
	localparam logic [mdc_pkg::CNT_W-1:0] RL_LAST    = mdc_pkg::CNT_W'(mdc_pkg::RL_CYC - 1);
	localparam logic [mdc_pkg::CNT_W-1:0] DATA_LAST  = mdc_pkg::CNT_W'(mdc_pkg::DATA_CLKS - 1);

	mdc_state_t                   state_q;
	mdc_state_t                   state_d;
	logic [mdc_pkg::CNT_W-1:0]    cnt_q;
	logic [mdc_pkg::CA_W-1:0]     tick_q [4];
	logic [1:0]                   idx_q;
	logic [1:0]                   last_q;
	logic                         is_rd_q;
	logic                         is_wr_q;
	logic                         sr_q;
	logic                         pd_q;
	logic [mdc_pkg::NBANK-1:0]    open_q;

	mdc_buf_if wbuf ();

	mdc_skid_buf u_wbuf (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.bi      (wbuf.fifo)
	);

	assign wbuf.in_valid  = wr_valid;
	assign wbuf.in_data   = wr_data;
	assign wr_ready       = wbuf.in_ready;
	assign wbuf.out_ready = (state_q == ST_WDATA);

	////////////////////////////////////////////////////////////////////////////////
	// Row width and non-binary guard per density
	logic [4:0] row_w;
	logic       non_bin;
	always_comb
	begin
		non_bin = 1'b0;
		case (density)
			mdc_pkg::DEN_2G:  row_w = 5'd14; // R11
			mdc_pkg::DEN_3G:  begin row_w = 5'd15; non_bin = 1'b1; end
			mdc_pkg::DEN_4G:  row_w = 5'd15;
			mdc_pkg::DEN_6G:  begin row_w = 5'd16; non_bin = 1'b1; end
			mdc_pkg::DEN_8G:  row_w = 5'd16;
			mdc_pkg::DEN_12G: begin row_w = 5'd17; non_bin = 1'b1; end
			default:          row_w = 5'd17;
		endcase
	end

	logic [mdc_pkg::ROW_W-1:0] row_fix;
	always_comb
	begin
		for (int i = 0; i < mdc_pkg::ROW_W; i++)
			row_fix[i] = (i < int'(row_w)) ? cmd_row[i] : 1'b0; // R14
		if (non_bin && row_fix[5'(row_w - 5'd1)])
			row_fix[5'(row_w - 5'd2)] = 1'b0; // R12
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command legality and tick building
	wire is_act   = (cmd_op == mdc_pkg::OP_ACT);
	wire is_col   = (cmd_op == mdc_pkg::OP_RD) || (cmd_op == mdc_pkg::OP_WR) ||
		(cmd_op == mdc_pkg::OP_MWR);
	wire is_mode  = (cmd_op == mdc_pkg::OP_MRW) || (cmd_op == mdc_pkg::OP_MRR) ||
		(cmd_op == mdc_pkg::OP_MPC);
	wire array_op = is_act || is_col || (cmd_op == mdc_pkg::OP_PRE) ||
		(cmd_op == mdc_pkg::OP_SRE);
	wire sr_ok    = is_mode || (cmd_op == mdc_pkg::OP_PDE) || (cmd_op == mdc_pkg::OP_PDX) ||
		(cmd_op == mdc_pkg::OP_SRX); // R15
	wire pd_ok    = (cmd_op == mdc_pkg::OP_PDX);
	wire take     = cmd_valid && cmd_ready;
	wire bad      = (array_op && !init_done) || // R10
		(is_col && !open_q[cmd_bank]) || // R8
		(is_act && open_q[cmd_bank]) ||
		((cmd_op == mdc_pkg::OP_SRE) && (open_q != '0)) ||
		(sr_q && !sr_ok) ||
		(!sr_q && (cmd_op == mdc_pkg::OP_SRX)) ||
		(pd_q && !pd_ok) ||
		(!pd_q && pd_ok);
	wire go       = take && !bad;
	wire cke_only = (cmd_op == mdc_pkg::OP_PDE) || (cmd_op == mdc_pkg::OP_PDX);

	logic [2:0]               sub;
	logic [mdc_pkg::CA_W-1:0] t0;
	logic [mdc_pkg::CA_W-1:0] t1;
	logic [mdc_pkg::CA_W-1:0] t2;
	logic [mdc_pkg::CA_W-1:0] t3;
	always_comb
	begin
		case (cmd_op)
			mdc_pkg::OP_RD:  sub = mdc_pkg::SUB_RD;
			mdc_pkg::OP_WR:  sub = mdc_pkg::SUB_WR;
			mdc_pkg::OP_MWR: sub = mdc_pkg::SUB_MWR;
			mdc_pkg::OP_PRE: sub = mdc_pkg::SUB_PRE;
			mdc_pkg::OP_MRW: sub = mdc_pkg::SUB_MRW;
			mdc_pkg::OP_MRR: sub = mdc_pkg::SUB_MRR;
			mdc_pkg::OP_MPC: sub = mdc_pkg::SUB_MPC;
			default:         sub = mdc_pkg::SUB_SR;
		endcase
		t0 = {mdc_pkg::MAJ_SINGLE, sub, 1'b0}; // R2
		t2 = {mdc_pkg::MAJ_CAS2, cmd_col[9:6]}; // R13
		t3 = {cmd_col[5:2], 2'h0}; // R13
		if (is_act)
		begin
			t0 = {mdc_pkg::MAJ_ACT1, cmd_bank, row_fix[16]}; // R8
			t1 = row_fix[15:10];
			t2 = {mdc_pkg::MAJ_ACT2, row_fix[9:6]};
			t3 = row_fix[5:0];
		end
		else if (is_mode)
			t1 = cmd_arg;
		else if ((cmd_op == mdc_pkg::OP_SRE) || (cmd_op == mdc_pkg::OP_SRX))
			t1 = {5'h0, (cmd_op == mdc_pkg::OP_SRE)};
		else
			t1 = {cmd_bank, 3'h0}; // R9
	end

	// Two-part commands end on tick index 3, single parts on 1
	wire [1:0] last_d = (is_act || is_col) ? 2'h3 : 2'h1; // R3

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	wire cnt_done = ((state_q == ST_RST) && (cnt_q == INIT1_LAST)) ||
		((state_q == ST_CKE) && (cnt_q == INIT3_LAST)) ||
		((state_q == ST_WAIT) && (cnt_q == (is_wr_q ? WL_LAST : RL_LAST))) ||
		(((state_q == ST_WDATA) || (state_q == ST_RDATA)) && (cnt_q == DATA_LAST));

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RST:   if (cnt_done) state_d = ST_CKE;
			ST_CKE:   if (cnt_done) state_d = ST_IDLE;
			ST_IDLE:  if (go && !cke_only) state_d = ST_SEND;
			ST_SEND:  if (idx_q == last_q) state_d = (is_rd_q || is_wr_q) ? ST_WAIT : ST_IDLE;
			ST_WAIT:  if (cnt_done) state_d = is_wr_q ? ST_WDATA : ST_RDATA;
			ST_WDATA: if (cnt_done) state_d = ST_IDLE;
			ST_RDATA: if (cnt_done) state_d = ST_IDLE;
			default:  state_d = ST_RST;
		endcase
	end

	assign cmd_ready = (state_q == ST_IDLE);

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= ST_RST;
			cnt_q   <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= (state_d != state_q || cnt_done) ? '0 : cnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < 4; i++)
				tick_q[i] <= '0;
			last_q  <= 2'h0;
			is_rd_q <= 1'b0;
			is_wr_q <= 1'b0;
		end
		else if (go)
		begin
			tick_q[0] <= t0;
			tick_q[1] <= t1;
			tick_q[2] <= t2;
			tick_q[3] <= t3;
			last_q    <= last_d;
			is_rd_q   <= (cmd_op == mdc_pkg::OP_RD);
			is_wr_q   <= (cmd_op == mdc_pkg::OP_WR) || (cmd_op == mdc_pkg::OP_MWR);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pins: CA launched on our rising edge, so it is stable at the device's next one
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			idx_q   <= 2'h0;
			dram_cs <= 1'b0;
			dram_ca <= '0;
		end
		else if (state_q == ST_SEND)
		begin
			idx_q   <= idx_q + 2'h1;
			dram_cs <= ~idx_q[0]; // R1
			dram_ca <= tick_q[idx_q]; // R16
		end
		else
		begin
			idx_q   <= 2'h0;
			dram_cs <= 1'b0;
			dram_ca <= '0; // R14
		end
	end

	// Device reset held through the first wait, CKE raised only after the second
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dram_reset_n <= 1'b0; // R17
			dram_cke     <= 1'b0;
			sr_q         <= 1'b0;
			pd_q         <= 1'b0;
		end
		else
		begin
			dram_reset_n <= dram_reset_n | (state_q == ST_CKE);
			dram_cke     <= (state_d == ST_IDLE && state_q == ST_CKE) ? 1'b1 :
				(go && cmd_op == mdc_pkg::OP_PDE) ? 1'b0 :
				(go && cmd_op == mdc_pkg::OP_PDX) ? 1'b1 : dram_cke;
			sr_q         <= go && (cmd_op == mdc_pkg::OP_SRE) ? 1'b1 :
				go && (cmd_op == mdc_pkg::OP_SRX) ? 1'b0 : sr_q;
			pd_q         <= go && (cmd_op == mdc_pkg::OP_PDE) ? 1'b1 :
				go && (cmd_op == mdc_pkg::OP_PDX) ? 1'b0 : pd_q;
		end
	end

	// One open-row flag per bank
	for (genvar b = 0; b < mdc_pkg::NBANK; b++)
	begin : g_bank
		wire hit = go && (cmd_bank == mdc_pkg::BANK_W'(b));
		always_ff @(posedge ref_clk or negedge reset_n)
		begin
			if (!reset_n)
				open_q[b] <= 1'b0;
			else if (hit && is_act)
				open_q[b] <= 1'b1; // R8
			else if (hit && cmd_op == mdc_pkg::OP_PRE)
				open_q[b] <= 1'b0;
		end
	end

	assign bank_open    = open_q;
	assign self_refresh = sr_q;

	////////////////////////////////////////////////////////////////////////////////
	// Data bursts: one 32-bit word per clock is one rising and one falling beat.
	// An empty write buffer mid-burst cannot stall the device, so zeros go out and
	// the error pulse tells the user the burst was corrupted.
	wire wr_beat = (state_q == ST_WDATA);
	wire rd_beat = (state_q == ST_RDATA);

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dq_out_rise <= '0;
			dq_out_fall <= '0;
			dq_oe       <= 1'b0;
			dqs_out     <= 1'b0;
			dqs_oe      <= 1'b0;
			rd_valid    <= 1'b0;
			rd_data     <= '0;
			cmd_err     <= 1'b0;
		end
		else
		begin
			dq_out_rise <= (wr_beat && wbuf.out_valid) ? wbuf.out_data[15:0] : '0; // R5
			dq_out_fall <= (wr_beat && wbuf.out_valid) ? wbuf.out_data[31:16] : '0; // R6
			dq_oe       <= wr_beat;
			dqs_out     <= wr_beat ? ~dqs_out : 1'b0;
			dqs_oe      <= wr_beat;
			rd_valid    <= rd_beat; // R7
			rd_data     <= rd_beat ? {dq_in_fall, dq_in_rise} : rd_data;
			cmd_err     <= (take && bad) || (wr_beat && !wbuf.out_valid);
		end
	end
endmodule

// ---- common/mdc_pkg.sv ----
package mdc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_INIT1_NS    = 200000;
	localparam int unsigned T_INIT3_NS    = 2000000;
	localparam int unsigned INIT1_CYC     = (T_INIT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned INIT3_CYC     = (T_INIT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WL_CYC        = 4;
	localparam int unsigned RL_CYC        = 6;
	localparam int unsigned BURST_LEN     = 16;
	localparam int unsigned DATA_CLKS     = BURST_LEN / 2;
	localparam int unsigned CNT_W         = 21;

	////////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int unsigned CA_W   = 6;
	localparam int unsigned DQ_W   = 16;
	localparam int unsigned WORD_W = 2 * DQ_W;
	localparam int unsigned BANK_W = 3;
	localparam int unsigned NBANK  = 8;
	localparam int unsigned ROW_W  = 17;
	localparam int unsigned COL_W  = 10;

	////////////////////////////////////////////////////////////////////////////////
	// Command/address encoding: major code in the top two bits of a part's first tick
	localparam logic [1:0] MAJ_SINGLE = 2'h0;
	localparam logic [1:0] MAJ_CAS2   = 2'h1;
	localparam logic [1:0] MAJ_ACT2   = 2'h2;
	localparam logic [1:0] MAJ_ACT1   = 2'h3;
	localparam logic [2:0] SUB_RD     = 3'h0;
	localparam logic [2:0] SUB_WR     = 3'h1;
	localparam logic [2:0] SUB_MWR    = 3'h2;
	localparam logic [2:0] SUB_PRE    = 3'h3;
	localparam logic [2:0] SUB_MRW    = 3'h4;
	localparam logic [2:0] SUB_MRR    = 3'h5;
	localparam logic [2:0] SUB_MPC    = 3'h6;
	localparam logic [2:0] SUB_SR     = 3'h7;

	typedef enum logic [3:0] {
		OP_ACT, OP_RD, OP_WR, OP_MWR, OP_PRE, OP_MRW, OP_MRR, OP_MPC,
		OP_SRE, OP_SRX, OP_PDE, OP_PDX
	} mdc_op_t;

	typedef enum logic [2:0] {
		DEN_2G, DEN_3G, DEN_4G, DEN_6G, DEN_8G, DEN_12G, DEN_16G
	} mdc_den_t;

endpackage

// ---- common/mdc_buf_if.sv ----
`timescale 1ns/1ps
interface mdc_buf_if;
	logic                        in_valid;
	logic                        in_ready;
	logic [mdc_pkg::WORD_W-1:0]  in_data;
	logic                        out_valid;
	logic                        out_ready;
	logic [mdc_pkg::WORD_W-1:0]  out_data;

	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ---- hdl/mdc_skid_buf.sv ----
`timescale 1ns/1ps
module mdc_skid_buf (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	mdc_buf_if.fifo   bi
);
	logic [mdc_pkg::WORD_W-1:0] mem_q [2];
	logic                       wp_q;
	logic                       rp_q;
	logic [1:0]                 cnt_q;
	wire                        push;
	wire                        pop;

	assign bi.in_ready  = (cnt_q != 2'h2);
	assign bi.out_valid = (cnt_q != 2'h0);
	assign bi.out_data  = mem_q[rp_q];
	assign push         = bi.in_valid && bi.in_ready;
	assign pop          = bi.out_valid && bi.out_ready;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			wp_q  <= wp_q ^ push;
			rp_q  <= rp_q ^ pop;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage needs no reset; occupancy guards every read
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem_q[wp_q] <= bi.in_data;
	end
endmodule

// ---- testbench/mdc_ctrl_properties.sv ----
`timescale 1ns/1ps
module mdc_chk (
	input wire logic              ref_clk,
	input wire logic              reset_n,
	input wire mdc_pkg::mdc_den_t density,
	input wire logic              init_done,
	input wire logic              cmd_valid,
	input wire logic              cmd_ready,
	input wire mdc_pkg::mdc_op_t  cmd_op,
	input wire logic [2:0]        cmd_bank,
	input wire logic              cmd_err,
	input wire logic [7:0]        bank_open,
	input wire logic              self_refresh,
	input wire logic              dram_reset_n,
	input wire logic              dram_cke,
	input wire logic              dram_cs,
	input wire logic [5:0]        dram_ca,
	input wire logic              dq_oe,
	input wire logic              dqs_out,
	input wire logic              dqs_oe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	wire       tk  = cmd_valid && cmd_ready;
	wire [1:0] maj = dram_ca[5:4];

	////////////////////////////////////////////////////////////////////////////////
	AST_CS_PULSE: assert property (dram_cs |=> !dram_cs)
		else $error("select held into second tick");
	AST_ACT_PAIR: assert property (dram_cs && maj == 2'h3 |-> ##2 dram_cs && maj == 2'h2)
		else $error("activate second part missing");
	AST_CAS_PAIR: assert property (dram_cs && maj == 2'h0 && dram_ca[3:1] <= 3'h2
		|-> ##2 dram_cs && maj == 2'h1)
		else $error("column part missing");
	AST_ACT_ISSUE: assert property (tk && init_done && dram_cke && !self_refresh
		&& cmd_op == mdc_pkg::OP_ACT && !bank_open[cmd_bank]
		|-> ##2 dram_cs && maj == 2'h3 && dram_ca[3:1] == $past(cmd_bank, 2))
		else $error("activate not issued with its bank");
	AST_RD_CLOSED: assert property (tk && cmd_op == mdc_pkg::OP_RD && !bank_open[cmd_bank]
		|=> cmd_err ##1 !dram_cs)
		else $error("read to closed bank not refused");
	AST_COL_LOW: assert property (dram_cs && maj == 2'h1 |=> dram_ca[1:0] == 2'h0)
		else $error("low column bits sent");
	AST_ROW_2G: assert property (dram_cs && maj == 2'h3 && density == mdc_pkg::DEN_2G
		|-> !dram_ca[0] ##1 maj == 2'h0)
		else $error("row bits beyond density width");
	AST_NONBIN: assert property (dram_cs && maj == 2'h3 && dram_ca[0]
		&& density == mdc_pkg::DEN_12G |=> !dram_ca[5])
		else $error("invalid quarter of row space");
	AST_SR_GATE: assert property (tk && self_refresh && cmd_op == mdc_pkg::OP_ACT
		|=> cmd_err && $stable(bank_open))
		else $error("activate taken in self refresh");
	AST_CKE_RST: assert property (dram_cke |-> dram_reset_n)
		else $error("clock enable while in reset");
	AST_STROBE: assert property (dq_oe |-> dqs_oe)
		else $error("data driven without strobe");
	AST_DQS_TOGGLE: assert property (dqs_oe && $past(dqs_oe) |-> dqs_out != $past(dqs_out))
		else $error("write strobe not toggling");

	cover property (tk && cmd_op == mdc_pkg::OP_RD && bank_open[cmd_bank]);
	cover property (dq_oe);
	cover property (tk && self_refresh);
endmodule

bind mdc_ctrl mdc_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .density(density),
	.init_done(init_done), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
	.cmd_bank(cmd_bank), .cmd_err(cmd_err), .bank_open(bank_open),
	.self_refresh(self_refresh), .dram_reset_n(dram_reset_n), .dram_cke(dram_cke),
	.dram_cs(dram_cs), .dram_ca(dram_ca), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

// ---- testbench/mdc_dev_model.sv ----
`timescale 1ns/1ps
module mdc_dev_model (
	input  wire logic        ref_clk,
	input  wire logic        dram_reset_n,
	input  wire logic        dram_cke,
	input  wire logic        dram_cs,
	input  wire logic [5:0]  dram_ca,
	output wire logic [15:0] dq_in_rise,
	output wire logic [15:0] dq_in_fall
);
	logic        hi_q;
	logic [5:0]  t0_q;
	logic [2:0]  sub_q;
	logic [2:0]  bank_q;
	logic [7:0]  open_q;
	logic [7:0]  col_q;
	logic [4:0]  rc_q;
	logic [15:0] noise_q;
	// Mode writes never move the read latency, even with a row open
	wire [4:0]   rl   = 5'(mdc_pkg::RL_CYC);
	// The host samples its first read beat on the edge after the count reaches rl
	wire         act  = rc_q >= rl;
	wire [3:0]   beat = 4'(rc_q - rl);
	// Outside a burst the lanes wander so a stale sample never matches
	wire [15:0]  word = act ? {bank_q, col_q, beat, 1'b0} : noise_q;

	assign dq_in_rise = word;
	assign dq_in_fall = ~word;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge dram_reset_n)
	begin
		if (!dram_reset_n)
		begin
			hi_q    <= 1'b0;
			t0_q    <= 6'h00;
			sub_q   <= 3'h0;
			bank_q  <= 3'h0;
			open_q  <= 8'h00;
			col_q   <= 8'h00;
			rc_q    <= 5'h00;
			noise_q <= 16'h5A5A;
		end
		else
		begin
			hi_q    <= dram_cs && dram_cke;
			t0_q    <= dram_ca;
			noise_q <= noise_q + 16'h3B1D;
			if (rc_q != 5'h00)
				rc_q <= (rc_q == rl + 5'h07) ? 5'h00 : rc_q + 5'h01;
			if (hi_q)
			begin
				case (t0_q[5:4])
					2'h3: bank_q <= t0_q[3:1];
					2'h2: open_q[bank_q] <= 1'b1;
					2'h1:
					begin
						// Reads to a closed bank get no data: the lanes keep wandering
						if (sub_q == mdc_pkg::SUB_RD && open_q[bank_q])
						begin
							rc_q  <= 5'h01;
							col_q <= {t0_q[3:0], dram_ca[5:2]};
						end
					end
					default:
					begin
						sub_q <= t0_q[3:1];
						if (t0_q[3:1] <= mdc_pkg::SUB_MWR)
							bank_q <= dram_ca[5:3];
						if (t0_q[3:1] == mdc_pkg::SUB_PRE)
							open_q[dram_ca[5:3]] <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic               ref_clk, reset_n, init_done, cmd_valid, wr_valid;
	mdc_pkg::mdc_den_t  density;
	mdc_pkg::mdc_op_t   cmd_op;
	logic [2:0]         cmd_bank, b;
	logic [16:0]        cmd_row;
	logic [9:0]         cmd_col;
	logic [5:0]         cmd_arg;
	logic [31:0]        wr_data, seed;
	logic [31:0]        rd_q[$], wr_q[$], wf_q[$];
	int                 err_q[$];
	int                 miscompares, n_tests, cyc;
	wire                cmd_ready, wr_ready, cmd_err, rd_valid, self_refresh;
	wire                dram_reset_n, dram_cke, dram_cs, dq_oe, dqs_out, dqs_oe;
	wire [31:0]         rd_data;
	wire [7:0]          bank_open;
	wire [5:0]          dram_ca;
	wire [15:0]         dq_out_rise, dq_out_fall, dq_in_rise, dq_in_fall;

	mdc_ctrl #(.INIT1_CYC(4), .INIT3_CYC(4)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.density(density), .init_done(init_done), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_row(cmd_row),
		.cmd_col(cmd_col), .cmd_arg(cmd_arg), .cmd_err(cmd_err), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
		.bank_open(bank_open), .self_refresh(self_refresh), .dram_reset_n(dram_reset_n),
		.dram_cke(dram_cke), .dram_cs(dram_cs), .dram_ca(dram_ca),
		.dq_out_rise(dq_out_rise), .dq_out_fall(dq_out_fall), .dq_oe(dq_oe),
		.dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall), .dqs_out(dqs_out),
		.dqs_oe(dqs_oe));
	mdc_dev_model u_dev (.ref_clk(ref_clk), .dram_reset_n(dram_reset_n),
		.dram_cke(dram_cke), .dram_cs(dram_cs), .dram_ca(dram_ca),
		.dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall));

	////////////////////////////////////////////////////////////////////////////////
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wrap_up;
		$display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One edge always passes, so a dropped request is never raised again in the same step
	task idle;
		@(posedge ref_clk);
		#1;
		for (int k = 0; k < 300 && cmd_ready !== 1'b1; k++)
		begin
			@(posedge ref_clk);
			#1;
		end
		chk(32'(cmd_ready), 32'h1);
	endtask

	// Every request opens at one ns past an edge and is held across one edge
	task send(input mdc_pkg::mdc_op_t op, input logic [2:0] bk, input logic [16:0] r,
		input logic [9:0] cl, input int e);
		idle();
		cmd_valid = 1'b1;
		cmd_op    = op;
		cmd_bank  = bk;
		cmd_row   = r;
		cmd_col   = cl;
		cmd_arg   = r[5:0];
		if (e != 0)
			err_q.push_back(1);
		@(posedge ref_clk);
		#1;
		cmd_valid = 1'b0;
	endtask

	task rd(input logic [2:0] bk, input logic [9:0] cl);
		logic [15:0] r;
		for (int k = 0; k < 8; k++)
		begin
			r = {bk, cl[9:2], 4'(k), 1'b0};
			rd_q.push_back({~r, r});
		end
		send(mdc_pkg::OP_RD, bk, 17'h00000, cl, 0);
	endtask

	task wr(input mdc_pkg::mdc_op_t op, input logic [2:0] bk);
		logic [31:0] d;
		for (int k = 0; k < 8; k++)
		begin
			d = xs();
			wf_q.push_back(d);
			wr_q.push_back(d);
		end
		for (int k = 0; k < 20 && wr_ready !== 1'b0; k++)
		begin
			@(posedge ref_clk);
			#1;
		end
		chk(32'(wr_ready), 32'h0);
		send(op, bk, 17'h00000, 10'(xs()), 0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	// Write feeder keeps the buffer topped up while words are queued
	always @(posedge ref_clk)
	begin
		if (reset_n === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1)
			void'(wf_q.pop_front());
		#1;
		wr_valid = wf_q.size() > 0;
		wr_data  = wf_q.size() > 0 ? wf_q[0] : xs();
	end

	always @(posedge ref_clk)
	begin
		if (reset_n === 1'b1)
		begin
			if (rd_valid === 1'b1)
				chk(rd_data, rd_q.size() > 0 ? rd_q.pop_front() : 32'hXXXXXXXX);
			if (dq_oe === 1'b1)
				chk({dq_out_fall, dq_out_rise}, wr_q.size() > 0 ? wr_q.pop_front() : 32'hXXXXXXXX);
			if (cmd_err === 1'b1)
				chk(32'h1, 32'(err_q.size() > 0 ? err_q.pop_front() : 0));
		end
	end

	initial
	begin
		seed = 32'h0001785D;
		{reset_n, init_done, cmd_valid, cmd_bank, cmd_row, cmd_col, cmd_arg} = '0;
		density = mdc_pkg::DEN_16G;
		cmd_op = mdc_pkg::OP_ACT;
		repeat (5) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		send(mdc_pkg::OP_ACT, 3'h1, 17'h00000, 10'h000, 1);
		init_done = 1'b1;
		send(mdc_pkg::OP_RD, 3'h2, 17'h00000, 10'h000, 1);
		send(mdc_pkg::OP_PDX, 3'h0, 17'h00000, 10'h000, 1);
		send(mdc_pkg::OP_SRX, 3'h0, 17'h00000, 10'h000, 1);
		for (int d = 0; d < 7; d++)
		begin
			density = mdc_pkg::mdc_den_t'(d);
			send(mdc_pkg::OP_ACT, 3'(d), 17'h1FFFF, 10'h000, 0);
			send(mdc_pkg::OP_PRE, 3'(d), 17'h00000, 10'h000, 0);
		end
		density = mdc_pkg::DEN_8G;
		b = 3'(xs());
		send(mdc_pkg::OP_ACT, b, 17'(xs()), 10'h000, 0);
		send(mdc_pkg::OP_ACT, b, 17'h00000, 10'h000, 1);
		chk(32'(bank_open[b]), 32'h1);
		send(mdc_pkg::OP_MRW, 3'h0, 17'(xs()), 10'h000, 0);
		rd(b, 10'(xs()));
		rd(b, 10'h3FF);
		wr(mdc_pkg::OP_WR, b);
		wr(mdc_pkg::OP_MWR, b);
		rd(b, 10'(xs()));
		send(mdc_pkg::OP_SRE, 3'h0, 17'h00000, 10'h000, 1);
		send(mdc_pkg::OP_PRE, b, 17'h00000, 10'h000, 0);
		send(mdc_pkg::OP_SRE, 3'h0, 17'h00000, 10'h000, 0);
		send(mdc_pkg::OP_ACT, b, 17'h00000, 10'h000, 1);
		chk(32'(self_refresh), 32'h1);
		send(mdc_pkg::OP_MRW, 3'h0, 17'(xs()), 10'h000, 0);
		send(mdc_pkg::OP_MRR, 3'h0, 17'(xs()), 10'h000, 0);
		send(mdc_pkg::OP_MPC, 3'h0, 17'(xs()), 10'h000, 0);
		send(mdc_pkg::OP_PDE, 3'h0, 17'h00000, 10'h000, 0);
		send(mdc_pkg::OP_ACT, b, 17'h00000, 10'h000, 1);
		send(mdc_pkg::OP_PDX, 3'h0, 17'h00000, 10'h000, 0);
		send(mdc_pkg::OP_SRX, 3'h0, 17'h00000, 10'h000, 0);
		send(mdc_pkg::OP_ACT, 3'h5, 17'(xs()), 10'h000, 0);
		idle();
		chk(32'(self_refresh), 32'h0);
		chk(32'(bank_open[5]), 32'h1);
		reset_n = 1'b0;
		#1;
		chk(32'({bank_open, dram_reset_n, dram_cke}), 32'h0);
		repeat (3) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		idle();
		chk(32'(bank_open), 32'h0);
		repeat (30) @(posedge ref_clk);
		chk(32'(rd_q.size() + wr_q.size() + err_q.size()), 32'h0);
		wrap_up();
	end
endmodule
